// ==== hdl/tcc_pkg.sv ====
package tcc_pkg;
  // register printed offsets (word index, compared with apb address bits 17 to 2)
  localparam logic [15:0] ADDR_CONTROL   = 16'hFE10;
  localparam logic [15:0] ADDR_PRESCALE  = 16'hFE11;
  localparam logic [15:0] ADDR_LOW_CNT   = 16'hFE12;
  localparam logic [15:0] ADDR_HIGH_CNT  = 16'hFE13;
  localparam logic [15:0] ADDR_LOW_MDAT  = 16'hFE14;
  localparam logic [15:0] ADDR_HIGH_MDAT = 16'hFE15;
  localparam logic [15:0] ADDR_LOW_CAP   = 16'hFE16;
  localparam logic [15:0] ADDR_HIGH_CAP  = 16'hFE17;
  // register word indices (offset not a multiple of four)
  localparam int unsigned IDX_BASE = 32'h0000FE10;
  // control bit positions
  localparam int unsigned BIT_HIGH_RUN  = 7;
  localparam int unsigned BIT_LOW_RUN   = 6;
  localparam int unsigned BIT_LENGTH    = 5;
  localparam int unsigned BIT_EXT_CLK   = 4;
  localparam int unsigned BIT_HIGH_FLAG = 3;
  localparam int unsigned BIT_HIGH_IE   = 2;
  localparam int unsigned BIT_LOW_FLAG  = 1;
  localparam int unsigned BIT_LOW_IE    = 0;
  localparam logic [7:0]  RESET_BYTE    = 8'h00;

  typedef struct packed {
    logic low_capture_input_a;
    logic high_capture_input_a;
    logic event_input_a;
    logic event_input_b;
  } tcc_det_t;

  typedef struct packed {
    logic low_irq;
    logic high_irq;
  } tcc_irq_t;
endpackage

// ==== hdl/tcc_timer.sv ====
// Design decision made here: register access over APB.
`timescale 1ns/1ps
// Overview of operation
// RULE1 - prescaler advances once every cycle clock
// RULE2 - prescaler pulses on equal to match value, period 1 to 256
// RULE3 - prescaler restarts at zero on pulse or match register write
// RULE4 - prescaler runs except in deep standby, where it halts
// RULE5 - low counter runs only while control bit 6 set
// RULE6 - high counter runs only while control bit 7 set
// RULE7 - bit 4 picks prescaler or external events for low counter
// RULE8 - bit 5 picks prescaler or low counter wrap for high counter
// RULE9 - external events come from event_input_a and event_input_b detection inputs
// RULE10 - match when count equals buffer; 16-bit mode compares all bits
// RULE11 - counter clears when stopped or on match
// RULE12 - low buffer tracks data while stopped, reloads on match
// RULE13 - high buffer tracks data while stopped, reloads on match
// RULE14 - low capture source is low input, or high input in 16-bit
// RULE15 - high capture latches high count on high capture pulse
// RULE16 - 16-bit modes capture both halves in the same cycle
// RULE17 - period is (match+1) times (prescale+1), or match+1 events
// RULE18 - enabled half requests interrupt on each match event
// RULE19 - mode 0 gives two independent 8-bit timers on shared tick
// RULE20 - match flag set on running match, cleared only by software
// RULE21 - 16-bit mode sets both flags together
// RULE22 - software writes both run bits together in 16-bit mode
// RULE23 - high request goes to vector 0023H, low to 0013H
// RULE24 - detection inputs are one-cycle pulses, one action each; simultaneous event_input_a and event_input_b pulses give one count
// RULE25 - writes to count and capture registers are ignored
// RULE26 - capture takes the count held before a same-cycle increment
module tcc_timer
(
  input  wire logic              i_clk_sys,
  input  wire logic              i_rst,
  input  wire logic              i_ce,
  input  wire logic              i_standby,
  input  wire tcc_pkg::tcc_det_t i_det,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  output tcc_pkg::tcc_irq_t      o_irq
);

  logic [7:0] control_r;
  logic [7:0] prescaler_match_r;
  logic [7:0] low_match_data_r;
  logic [7:0] high_match_data_r;
  logic [7:0] low_count_r;
  logic [7:0] high_count_r;
  logic [7:0] low_buf_r;
  logic [7:0] high_buf_r;
  logic [7:0] low_capture_r;
  logic [7:0] high_capture_r;
  logic [7:0] pre_cnt_r;
  logic [31:0] prdata_r;

  logic        wr_acc;
  logic        rd_acc;
  logic        hit;
  logic [15:0] word_idx;
  logic [15:0] sel_addr;
  logic        run_lo;
  logic        run_hi;
  logic        long_mode;
  logic        ext_mode;
  logic        pre_tick;
  logic        ext_evt;
  logic        lo_inc;
  logic        hi_inc;
  logic        lo_match;
  logic        hi_match;
  logic        full_match;
  logic        cap_lo;
  logic        cap_hi;
  logic        lo_wrap;
  logic        lo_src;
  logic        hi_src;
  logic        lo_eq;
  logic        hi_eq;
  logic        wr_ctl;
  logic        wr_pre;
  logic        wr_lmd;
  logic        wr_hmd;
  logic [7:0]  rd_byte;

  // operating modes from length and external-clock bits
  typedef enum logic [1:0]
  {
    MODE_DUAL_TIMER,
    MODE_TIMER_EVENT,
    MODE_WIDE_TIMER,
    MODE_WIDE_EVENT
  } tcc_mode_t;

  tcc_mode_t   mode;

  assign run_lo    = control_r[tcc_pkg::BIT_LOW_RUN];
  assign run_hi    = control_r[tcc_pkg::BIT_HIGH_RUN];
  assign long_mode = control_r[tcc_pkg::BIT_LENGTH];
  assign ext_mode  = control_r[tcc_pkg::BIT_EXT_CLK];

  // apb decode: byte address is four times the printed offset
  assign word_idx = paddr[17:2];
  assign sel_addr = word_idx;
  assign hit      = (paddr[1:0] == 2'h0)
                  && (sel_addr >= tcc_pkg::ADDR_CONTROL)
                  && (sel_addr <= tcc_pkg::ADDR_HIGH_CAP)
                  && (paddr[31:18] == 14'h0000);
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !hit;
  assign wr_acc   = psel && penable && pwrite && hit && pstrb[0] && i_ce;
  assign rd_acc   = psel && !penable && !pwrite;
  assign prdata   = prdata_r;

  // per-register write strobes
  assign wr_ctl   = wr_acc && (sel_addr == tcc_pkg::ADDR_CONTROL);
  assign wr_pre   = wr_acc && (sel_addr == tcc_pkg::ADDR_PRESCALE);
  assign wr_lmd   = wr_acc && (sel_addr == tcc_pkg::ADDR_LOW_MDAT);
  assign wr_hmd   = wr_acc && (sel_addr == tcc_pkg::ADDR_HIGH_MDAT);

  // RULE1 base tick
  // RULE2 prescaler match
  assign pre_tick = (pre_cnt_r == prescaler_match_r) && !i_standby;

  // RULE9 external events
  // RULE24 one count per event cycle; event_input_a and event_input_b together give one, not two
  assign ext_evt = i_det.event_input_a || i_det.event_input_b;

  // mode decode
  always_comb
  begin
    case ({long_mode, ext_mode})
      2'b00:   mode = MODE_DUAL_TIMER;
      2'b01:   mode = MODE_TIMER_EVENT;
      2'b10:   mode = MODE_WIDE_TIMER;
      default: mode = MODE_WIDE_EVENT;
    endcase
  end

  // RULE7 low source select
  // RULE8 high source select
  // RULE19 shared tick
  always_comb
  begin
    lo_src = 1'b0;
    hi_src = 1'b0;
    lo_eq  = 1'b0;
    hi_eq  = 1'b0;
    cap_lo = 1'b0;
    case (mode)
      MODE_DUAL_TIMER:
      begin
        lo_src = pre_tick;
        hi_src = pre_tick;
        lo_eq  = (low_count_r == low_buf_r);
        hi_eq  = (high_count_r == high_buf_r);
        cap_lo = i_det.low_capture_input_a;
      end
      MODE_TIMER_EVENT:
      begin
        lo_src = ext_evt;
        hi_src = pre_tick;
        lo_eq  = (low_count_r == low_buf_r);
        hi_eq  = (high_count_r == high_buf_r);
        cap_lo = i_det.low_capture_input_a;
      end
      MODE_WIDE_TIMER:
      begin
        lo_src = pre_tick;
        hi_src = 1'b0;
        // RULE10 all sixteen bits
        lo_eq  = full_match && run_hi;
        hi_eq  = 1'b0;
        // RULE14 high input captures low
        // RULE16 both halves together
        cap_lo = i_det.high_capture_input_a;
      end
      MODE_WIDE_EVENT:
      begin
        lo_src = ext_evt;
        hi_src = 1'b0;
        // RULE10 all sixteen bits
        lo_eq  = full_match && run_hi;
        hi_eq  = 1'b0;
        // RULE14 high input captures low
        // RULE16 both halves together
        cap_lo = i_det.high_capture_input_a;
      end
      default:
      begin
        lo_src = 1'b0;
        hi_src = 1'b0;
      end
    endcase
  end

  assign lo_inc = run_lo && lo_src;
  assign hi_inc = run_hi && hi_src;

  // RULE10 match compare
  assign full_match = ({high_count_r, low_count_r} ==
                       {high_buf_r, low_buf_r});
  assign lo_match = lo_inc && lo_eq;
  // RULE8 high counts low wraps in 16-bit mode
  assign lo_wrap  = long_mode && lo_inc && (low_count_r == 8'hFF);
  assign hi_match = long_mode ? lo_match : (hi_inc && hi_eq);

  // RULE15 high capture source
  assign cap_hi = i_det.high_capture_input_a;

  // read mux, unmapped reads return zero
  always_comb
  begin
    case (sel_addr)
      tcc_pkg::ADDR_CONTROL:   rd_byte = control_r;
      tcc_pkg::ADDR_PRESCALE:  rd_byte = prescaler_match_r;
      tcc_pkg::ADDR_LOW_CNT:   rd_byte = low_count_r;
      tcc_pkg::ADDR_HIGH_CNT:  rd_byte = high_count_r;
      tcc_pkg::ADDR_LOW_MDAT:  rd_byte = low_match_data_r;
      tcc_pkg::ADDR_HIGH_MDAT: rd_byte = high_match_data_r;
      tcc_pkg::ADDR_LOW_CAP:   rd_byte = low_capture_r;
      tcc_pkg::ADDR_HIGH_CAP:  rd_byte = high_capture_r;
      default:                 rd_byte = 8'h00;
    endcase
  end

  // read data latched at the setup edge, held until the next read
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      prdata_r <= 32'h0000_0000;
    else if (i_ce && rd_acc)
      prdata_r <= hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
  end

  // control register, flags set by hardware win over software clear
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      control_r <= tcc_pkg::RESET_BYTE;
    else if (i_ce)
    begin
      if (wr_ctl)
        control_r <= pwdata[7:0];
      // RULE20 sticky flags
      // RULE21 flags together
      if (lo_match)
        control_r[tcc_pkg::BIT_LOW_FLAG] <= 1'b1;
      if (hi_match)
        control_r[tcc_pkg::BIT_HIGH_FLAG] <= 1'b1;
    end
  end

  // RULE25 read-only registers ignore writes
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      prescaler_match_r <= tcc_pkg::RESET_BYTE;
      low_match_data_r  <= tcc_pkg::RESET_BYTE;
      high_match_data_r <= tcc_pkg::RESET_BYTE;
    end
    else if (wr_acc)
    begin
      if (wr_pre)
        prescaler_match_r <= pwdata[7:0];
      if (wr_lmd)
        low_match_data_r <= pwdata[7:0];
      if (wr_hmd)
        high_match_data_r <= pwdata[7:0];
    end
  end

  // prescaler
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
      pre_cnt_r <= 8'h00;
    else if (i_ce)
    begin
      // RULE3 restart on write or match
      if (wr_pre)
        pre_cnt_r <= 8'h00;
      // RULE4 halt in standby
      else if (i_standby)
        pre_cnt_r <= pre_cnt_r;
      else if (pre_tick)
        pre_cnt_r <= 8'h00;
      else
        pre_cnt_r <= pre_cnt_r + 8'h01;
    end
  end

  // low counter and buffer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      low_count_r <= 8'h00;
      low_buf_r   <= 8'h00;
    end
    else if (i_ce)
    begin
      // RULE5 run control
      // RULE11 clear when stopped or matched
      // RULE17 period match plus one
      if (!run_lo || lo_match)
        low_count_r <= 8'h00;
      else if (lo_inc)
        low_count_r <= low_count_r + 8'h01;
      // RULE12 low buffer update
      if (!run_lo || lo_match)
        low_buf_r <= low_match_data_r;
    end
  end

  // high counter and buffer
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      high_count_r <= 8'h00;
      high_buf_r   <= 8'h00;
    end
    else if (i_ce)
    begin
      // RULE6 run control
      // RULE11 clear when stopped or matched
      if (!run_hi || hi_match)
        high_count_r <= 8'h00;
      else if (lo_wrap)
        high_count_r <= high_count_r + 8'h01;
      else if (hi_inc)
        high_count_r <= high_count_r + 8'h01;
      // RULE13 high buffer update
      if (!run_hi || hi_match)
        high_buf_r <= high_match_data_r;
    end
  end

  // captures take the registered count, before any same-cycle increment
  always_ff @(posedge i_clk_sys)
  begin
    if (i_rst)
    begin
      low_capture_r  <= 8'h00;
      high_capture_r <= 8'h00;
    end
    else if (i_ce)
    begin
      // RULE14 low capture
      // RULE16 both halves together
      // RULE26 pre-increment value
      if (cap_lo)
        low_capture_r <= low_count_r;
      // RULE15 high capture
      if (cap_hi)
        high_capture_r <= high_count_r;
    end
  end

  // RULE18 interrupt requests
  // RULE23 low to 0013H vector line, high to 0023H vector line
  always_comb
  begin
    o_irq.low_irq  = control_r[tcc_pkg::BIT_LOW_FLAG]
                   && control_r[tcc_pkg::BIT_LOW_IE];
    o_irq.high_irq = control_r[tcc_pkg::BIT_HIGH_FLAG]
                   && control_r[tcc_pkg::BIT_HIGH_IE];
  end

endmodule // tcc_timer

// ==== sim/tcc_monitor.sv ====
`timescale 1ns/1ps
module tcc_monitor
(
  input wire logic              i_clk_sys,
  input wire logic              i_rst,
  input wire logic              i_ce,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire tcc_pkg::tcc_irq_t o_irq
);
  logic       wr_c;
  logic [2:0] mode_r;
  assign wr_c = psel && penable && pwrite && pstrb[0] && i_ce &&
                paddr == 32'h0003F840;
  // shadow of length and enable bits
  always_ff @(posedge i_clk_sys)
    if (i_rst)
      mode_r <= 3'h0;
    else if (wr_c)
      mode_r <= {pwdata[5], pwdata[2], pwdata[0]};
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  sequence long_low_rise;
    mode_r == 3'h7 ##0 $rose(o_irq.low_irq);
  endsequence
  ready_high_a: assert property (pready)
    else $error("pready low");
  err_phase_a: assert property (pslverr |-> psel && penable)
    else $error("error outside access phase");
  unmapped_err_a: assert property (psel && penable &&
    paddr == 32'h0003F860 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  rdata_hold_a: assert property (!$past(psel && !penable && !pwrite)
    |-> $stable(prdata)) else $error("read data moved");
  flag_sticky_a:
    assert property (!wr_c |=> ($past(o_irq) & ~o_irq) == 2'h0)
    else $error("request dropped without write");
  low_clear_a:
    assert property (wr_c && !pwdata[0] |=> !o_irq.low_irq)
    else $error("low request with enable off");
  high_clear_a:
    assert property (wr_c && !pwdata[2] |=> !o_irq.high_irq)
    else $error("high request with enable off");
  both_flags_a:
    assert property (long_low_rise |-> o_irq.high_irq)
    else $error("16-bit flags not together");
endmodule // tcc_monitor
bind tcc_timer tcc_monitor u_mon
(
  .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .o_irq(o_irq)
);

// ==== sim/tcc_det_src.sv ====
`timescale 1ns/1ps
module tcc_det_src
(
  input  wire logic         i_clk_sys,
  output tcc_pkg::tcc_det_t o_det
);
  initial o_det = '0;
  task automatic pulse(input logic [3:0] v, input int gap);
    @(posedge i_clk_sys);
    o_det <= tcc_pkg::tcc_det_t'(v);
    @(posedge i_clk_sys);
    o_det <= '0;
    repeat (gap) @(posedge i_clk_sys);
  endtask
endmodule // tcc_det_src

// ==== sim/tcc_timer_tb.sv ====
`timescale 1ns/1ps
module tcc_timer_tb;
  logic              i_clk_sys = 1'b0;
  logic              i_rst     = 1'b1;
  logic              i_standby = 1'b0;
  logic              i_ce      = 1'b1;
  logic              psel      = 1'b0;
  logic              penable   = 1'b0;
  logic              pwrite    = 1'b0;
  logic [31:0]       paddr     = 32'h0;
  logic [31:0]       pwdata    = 32'h0;
  logic [31:0]       prdata;
  logic [31:0]       q;
  logic              pready, pslverr, e;
  tcc_pkg::tcc_det_t det;
  tcc_pkg::tcc_irq_t irq;
  int                failures  = 0;
  int                checks    = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  tcc_timer u_dut
  (
    .i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_ce(i_ce),
    .i_standby(i_standby), .i_det(det), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .o_irq(irq)
  );
  tcc_det_src u_src (.i_clk_sys(i_clk_sys), .o_det(det));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; a read compares against d
  task automatic apb(input logic w, input logic [15:0] a,
                     input logic [7:0] d);
    @(posedge i_clk_sys);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= {14'h0, a, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge i_clk_sys);
    penable <= 1'b1;
    do @(posedge i_clk_sys); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (!w)
      chk(q[7:0], d);
  endtask
  task automatic wait_low(input int lim);
    @(negedge i_clk_sys);
    repeat (lim)
      if (irq.low_irq !== 1'b1)
        @(negedge i_clk_sys);
    chk({7'h0, irq.low_irq}, 8'h01);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic t_regs;
    for (int i = 0; i < 8; i++)
      apb(1'b0, 16'hFE10 + 16'(i), 8'h00);
    apb(1'b1, 16'hFE11, 8'h5A);
    apb(1'b0, 16'hFE11, 8'h5A);
    i_ce <= 1'b0;
    apb(1'b1, 16'hFE11, 8'h33);
    i_ce <= 1'b1;
    apb(1'b0, 16'hFE11, 8'h5A);
    apb(1'b1, 16'hFE12, 8'hC3);
    apb(1'b0, 16'hFE12, 8'h00);
    apb(1'b1, 16'hFE17, 8'hC3);
    apb(1'b0, 16'hFE17, 8'h00);
    apb(1'b0, 16'hFE18, 8'h00);
    chk({7'h0, e}, 8'h01);
  endtask
  task automatic t_period;
    time t0;
    apb(1'b1, 16'hFE11, 8'h02);
    apb(1'b1, 16'hFE14, 8'h03);
    apb(1'b1, 16'hFE15, 8'h01);
    apb(1'b1, 16'hFE10, 8'hC5);
    wait_low(100);
    chk({7'h0, irq.high_irq}, 8'h01);
    t0 = $time;
    apb(1'b1, 16'hFE10, 8'hC5);
    wait_low(100);
    chk(8'(($time - t0) / 10), 8'h0C);
    apb(1'b1, 16'hFE10, 8'hC5);
    i_standby <= 1'b1;
    repeat (40) @(negedge i_clk_sys);
    chk({7'h0, irq.low_irq}, 8'h00);
    chk({7'h0, irq.high_irq}, 8'h00);
    @(posedge i_clk_sys);
    i_standby <= 1'b0;
  endtask
  task automatic t_events;
    apb(1'b1, 16'hFE10, 8'h00);
    apb(1'b1, 16'hFE14, 8'h02);
    apb(1'b1, 16'hFE10, 8'h51);
    u_src.pulse(4'h2, 3);
    u_src.pulse(4'h1, 0);
    apb(1'b0, 16'hFE12, 8'h02);
    u_src.pulse(4'h8, 0);
    apb(1'b0, 16'hFE16, 8'h02);
    chk({7'h0, irq.low_irq}, 8'h00);
    u_src.pulse(4'h1, 0);
    wait_low(4);
    apb(1'b0, 16'hFE12, 8'h00);
  endtask
  task automatic t_cap16;
    apb(1'b1, 16'hFE10, 8'h00);
    apb(1'b1, 16'hFE14, 8'hFF);
    apb(1'b1, 16'hFE15, 8'hFF);
    apb(1'b1, 16'hFE10, 8'hF0);
    repeat (3) u_src.pulse(4'h2, 1);
    u_src.pulse(4'h8, 0);
    apb(1'b0, 16'hFE16, 8'h02);
    u_src.pulse(4'h5, 0);
    apb(1'b0, 16'hFE16, 8'h03);
    apb(1'b0, 16'hFE17, 8'h00);
    apb(1'b0, 16'hFE12, 8'h04);
  endtask
  task automatic t_long;
    apb(1'b1, 16'hFE10, 8'h00);
    apb(1'b1, 16'hFE11, 8'h00);
    apb(1'b1, 16'hFE14, 8'h01);
    apb(1'b1, 16'hFE15, 8'h01);
    apb(1'b1, 16'hFE10, 8'hE5);
    repeat (200) @(negedge i_clk_sys);
    chk({7'h0, irq.low_irq}, 8'h00);
    wait_low(100);
    chk({7'h0, irq.high_irq}, 8'h01);
  endtask
  initial
  begin
    #100000;
    failures++;
    stop_test;
  end
  initial
  begin
    repeat (12) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_regs;
    t_period;
    t_events;
    t_cap16;
    t_long;
    stop_test;
  end
endmodule // tcc_timer_tb
